// >>> rtl/jtc_top.sv
`timescale 1ns/1ps
// What this block does
// - after reset two controllers sit in the chain: boundary then chip
// - boundary controller follows the standard and scans the I/O pins
// - chip controller reaches tile, switch and otp for code and debug
// - test reset held low keeps the whole test port in reset
// - identification word: version, part number, maker, from the top
// - user code word: user id, unused bits, silicon revision, from the top
// - user id taken from security bits 31..22, zero when blank
// - security word loaded from otp at power-up before it takes effect
// - otp is four sectors of 512 rows of 32 bits
// - remaining otp rows copied to sram, then the processor runs them
// - programming via 16-bit address, 32-bit data, 16-bit control ports
// - system reset active low, asserts asynchronously, then pll lock, then boot
// - security bit 0 disables the test port entirely
// - security bit 13 blocks test-port otp reads and writes
// - test port steps on the test clock, test reset acts asynchronously
module jtc_top #(
  parameter int          PINS       = 8,
  parameter logic [3:0]  ID_VERSION = 4'h1,      // arbitrary value
  parameter logic [15:0] ID_PART    = 16'h0A5C,  // arbitrary value
  parameter logic [10:0] ID_MAKER   = 11'h155,   // arbitrary value
  parameter logic [15:0] SI_REV     = 16'h0001   // arbitrary value
) (
  // system
  input  wire logic            clock,
  input  wire logic            rst,
  input  wire logic            sys_rst_n,
  input  wire logic            pll_lock,
  // test port
  input  wire logic            tck,
  input  wire logic            tms,
  input  wire logic            tdi,
  input  wire logic            trst_n,
  output logic                 tdo,
  output logic                 tdo_oe_n,
  // pads
  input  wire logic [PINS-1:0] core_out,
  input  wire logic [PINS-1:0] core_oe_n,
  input  wire logic [PINS-1:0] pad_in,
  output logic [PINS-1:0]      pad_out,
  output logic [PINS-1:0]      pad_oe_n,
  // tile and switch debug
  output logic                 dbg_wr,
  output logic [39:0]          dbg_word,
  input  wire logic [31:0]     dbg_rd_data,
  // boot copy into sram
  output logic                 sram_we,
  output logic [10:0]          sram_addr,
  output logic [31:0]          sram_data,
  output logic                 core_start,
  output logic                 boot_otp,
  // otp programming ports
  output logic [23:0]          otp_port_id
);
  localparam logic [6:0]  LEN_BS    = 7'(2*PINS);
  localparam logic [31:0] IDENT_VAL = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

  function automatic logic [63:0] dr_shift(
    input logic [63:0] sr,
    input logic [6:0]  len,
    input logic        b
  );
    logic [63:0] r;
    r = sr >> 1;
    r[6'(len - 7'h01)] = b;
    return r;
  endfunction : dr_shift

  logic                  tck_q;
  logic                  tck_rise;
  logic                  tck_fall;
  logic [31:0]           sec;
  logic                  sec_valid;
  logic                  port_en;
  jtc_pkg::jtc_tap_e     bs_st;
  jtc_pkg::jtc_tap_e     ch_st;
  logic [3:0]            bs_ir;
  logic [3:0]            ch_ir;
  logic                  bs_ir_tdo;
  logic                  ch_ir_tdo;
  logic                  bs_tdo_q;
  logic [63:0]           bs_sr;
  logic [63:0]           ch_sr;
  logic [6:0]            bs_len;
  logic [6:0]            ch_len;
  logic [63:0]           bs_cap;
  logic [63:0]           ch_cap;
  logic [2*PINS-1:0]     bs_upd;
  logic                  extest;
  logic [31:0]           ucode_val;
  logic [15:0]           otp_adr;
  logic [31:0]           otp_wdat;
  logic [31:0]           otp_rdat;
  logic                  otp_denied;
  logic                  otp_refused;
  logic                  jt_rd_pend;
  logic                  ctl_upd;
  jtc_pkg::jtc_otp_req_s jt_req;
  jtc_pkg::jtc_otp_req_s bt_req;
  jtc_pkg::jtc_otp_req_s otp_req;
  logic [31:0]           otp_q;
  logic                  wr_refused;
  jtc_pkg::jtc_boot_e    boot_st;
  jtc_pkg::jtc_boot_e    next_boot_st;
  logic [10:0]           row;

  // test clock is a sampled input; its edges become enables
  always_ff @(posedge clock) begin
    if (rst) begin
      tck_q <= 1'b0;
    end else begin
      tck_q <= tck;
    end
  end

  assign tck_rise = tck && !tck_q;
  assign tck_fall = !tck && tck_q;

  // port stays shut until the security word is known
  assign port_en = sec_valid && !sec[jtc_pkg::SEC_PORT_OFF];

  // boundary controller first in the chain, chip controller second
  jtc_tap #(
    .IR_RESET (jtc_pkg::INS_IDENT)
  ) u_bs_tap (
    .clock    (clock),
    .rst      (rst),
    .trst_n   (trst_n),
    .hold     (!port_en),
    .tck_rise (tck_rise),
    .tms      (tms),
    .tdi      (tdi),
    .state    (bs_st),
    .ir       (bs_ir),
    .ir_tdo   (bs_ir_tdo)
  );

  jtc_tap #(
    .IR_RESET (jtc_pkg::INS_IDENT)
  ) u_ch_tap (
    .clock    (clock),
    .rst      (rst),
    .trst_n   (trst_n),
    .hold     (!port_en),
    .tck_rise (tck_rise),
    .tms      (tms),
    .tdi      (bs_tdo_q),
    .state    (ch_st),
    .ir       (ch_ir),
    .ir_tdo   (ch_ir_tdo)
  );

  // boundary data registers
  assign extest = bs_ir == jtc_pkg::INS_EXTEST;

  always_comb begin
    bs_len = jtc_pkg::LEN_BYP;
    bs_cap = '0;
    case (bs_ir)
      jtc_pkg::INS_EXTEST, jtc_pkg::INS_SAMPLE: begin
        bs_len = LEN_BS;
        bs_cap = 64'({core_oe_n, pad_in});
      end
      jtc_pkg::INS_IDENT: begin
        bs_len = jtc_pkg::LEN_ID;
        bs_cap = 64'(IDENT_VAL);
      end
      default: begin
        bs_len = jtc_pkg::LEN_BYP;
      end
    endcase
  end

  always_ff @(posedge clock or negedge trst_n) begin
    if (!trst_n) begin
      bs_sr  <= '0;
      bs_upd <= {{PINS{1'b1}}, {PINS{1'b0}}};
    end else if (rst || !port_en || bs_st == jtc_pkg::TS_RESET) begin
      bs_sr  <= '0;
      bs_upd <= {{PINS{1'b1}}, {PINS{1'b0}}};
    end else if (tck_rise) begin
      if (bs_st == jtc_pkg::TS_CAP_DR) begin
        bs_sr <= bs_cap;
      end else if (bs_st == jtc_pkg::TS_SH_DR) begin
        bs_sr <= dr_shift(bs_sr, bs_len, tdi);
      end else if (bs_st == jtc_pkg::TS_UPD_DR && bs_len == LEN_BS) begin
        bs_upd <= bs_sr[2*PINS-1:0];
      end
    end
  end

  // update latch drives the pads only under external test
  assign pad_out  = extest ? bs_upd[PINS-1:0]      : core_out;
  assign pad_oe_n = extest ? bs_upd[2*PINS-1:PINS] : core_oe_n;

  // hand-off to the chip controller on the falling edge
  always_ff @(posedge clock or negedge trst_n) begin
    if (!trst_n) begin
      bs_tdo_q <= 1'b0;
    end else if (rst) begin
      bs_tdo_q <= 1'b0;
    end else if (tck_fall) begin
      bs_tdo_q <= (bs_st == jtc_pkg::TS_SH_IR) ? bs_ir_tdo : bs_sr[0];
    end
  end

  // chip data registers
  assign ucode_val = {sec[jtc_pkg::SEC_UID_LSB +: jtc_pkg::UID_W], 6'h00, SI_REV};

  always_comb begin
    ch_len = jtc_pkg::LEN_BYP;
    ch_cap = '0;
    case (ch_ir)
      jtc_pkg::INS_IDENT: begin
        ch_len = jtc_pkg::LEN_ID;
        ch_cap = 64'(IDENT_VAL);
      end
      jtc_pkg::INS_UCODE: begin
        ch_len = jtc_pkg::LEN_ID;
        ch_cap = 64'(ucode_val);
      end
      jtc_pkg::INS_OTP_ADR: begin
        ch_len = jtc_pkg::LEN_ADR;
        ch_cap = 64'(otp_adr);
      end
      jtc_pkg::INS_OTP_DAT: begin
        ch_len = jtc_pkg::LEN_DAT;
        ch_cap = 64'(otp_rdat);
      end
      jtc_pkg::INS_OTP_CTL: begin
        ch_len = jtc_pkg::LEN_CTL;
        ch_cap = 64'({otp_refused, otp_denied});
      end
      jtc_pkg::INS_DEBUG: begin
        ch_len = jtc_pkg::LEN_DBG;
        ch_cap = 64'(dbg_rd_data);
      end
      default: begin
        ch_len = jtc_pkg::LEN_BYP;
      end
    endcase
  end

  always_ff @(posedge clock or negedge trst_n) begin
    if (!trst_n) begin
      ch_sr <= '0;
    end else if (rst || !port_en) begin
      ch_sr <= '0;
    end else if (tck_rise) begin
      if (ch_st == jtc_pkg::TS_CAP_DR) begin
        ch_sr <= ch_cap;
      end else if (ch_st == jtc_pkg::TS_SH_DR) begin
        ch_sr <= dr_shift(ch_sr, ch_len, bs_tdo_q);
      end
    end
  end

  assign ctl_upd = tck_rise && ch_st == jtc_pkg::TS_UPD_DR && ch_ir == jtc_pkg::INS_OTP_CTL;

  // update side: otp programming ports and tile debug
  always_ff @(posedge clock or negedge trst_n) begin
    if (!trst_n) begin
      otp_adr     <= '0;
      otp_wdat    <= '0;
      otp_port_id <= '0;
      dbg_word    <= '0;
      dbg_wr      <= 1'b0;
      jt_req      <= '0;
    end else if (rst || !port_en) begin
      otp_adr     <= '0;
      otp_wdat    <= '0;
      otp_port_id <= '0;
      dbg_word    <= '0;
      dbg_wr      <= 1'b0;
      jt_req      <= '0;
    end else begin
      dbg_wr <= 1'b0;
      jt_req <= '0;
      if (tck_rise && ch_st == jtc_pkg::TS_UPD_DR) begin
        case (ch_ir)
          jtc_pkg::INS_OTP_ADR: begin
            otp_adr     <= ch_sr[15:0];
            otp_port_id <= jtc_pkg::PORT_ID_ADR;
          end
          jtc_pkg::INS_OTP_DAT: begin
            otp_wdat    <= ch_sr[31:0];
            otp_port_id <= jtc_pkg::PORT_ID_DAT;
          end
          jtc_pkg::INS_OTP_CTL: begin
            otp_port_id <= jtc_pkg::PORT_ID_CTL;
            // boot owns the array until the copy is done
            if (!sec[jtc_pkg::SEC_OTP_OFF] && boot_st == jtc_pkg::BT_RUN) begin
              jt_req.rd   <= ch_sr[jtc_pkg::CTL_RD];
              jt_req.wr   <= ch_sr[jtc_pkg::CTL_PROG];
              jt_req.addr <= otp_adr[10:0];
              jt_req.data <= otp_wdat;
            end
          end
          jtc_pkg::INS_DEBUG: begin
            dbg_word <= ch_sr[39:0];
            dbg_wr   <= 1'b1;
          end
          default: begin
            dbg_wr <= 1'b0;
          end
        endcase
      end
    end
  end

  // otp read-back and sticky status; a new set beats the clear
  always_ff @(posedge clock or negedge trst_n) begin
    if (!trst_n) begin
      otp_rdat    <= '0;
      jt_rd_pend  <= 1'b0;
      otp_denied  <= 1'b0;
      otp_refused <= 1'b0;
    end else if (rst || !port_en) begin
      otp_rdat    <= '0;
      jt_rd_pend  <= 1'b0;
      otp_denied  <= 1'b0;
      otp_refused <= 1'b0;
    end else begin
      jt_rd_pend <= jt_req.rd;
      if (jt_rd_pend) begin
        otp_rdat <= otp_q;
      end
      if (ctl_upd && (sec[jtc_pkg::SEC_OTP_OFF] || boot_st != jtc_pkg::BT_RUN)) begin
        otp_denied <= 1'b1;
      end else if (ctl_upd) begin
        otp_denied <= 1'b0;
      end
      if (wr_refused && boot_st == jtc_pkg::BT_RUN) begin
        otp_refused <= 1'b1;
      end else if (ctl_upd) begin
        otp_refused <= 1'b0;
      end
    end
  end

  // test data out changes on the falling edge
  always_ff @(posedge clock or negedge trst_n) begin
    if (!trst_n) begin
      tdo      <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else if (rst || !port_en) begin
      tdo      <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else if (tck_fall) begin
      tdo      <= (ch_st == jtc_pkg::TS_SH_IR) ? ch_ir_tdo : ch_sr[0];
      tdo_oe_n <= !(ch_st == jtc_pkg::TS_SH_IR || ch_st == jtc_pkg::TS_SH_DR);
    end
  end

  // otp array: boot sequencer first, test port afterwards
  assign otp_req = (boot_st == jtc_pkg::BT_RUN) ? jt_req : bt_req;

  jtc_otp #(
    .SECTORS (jtc_pkg::SECTORS),
    .ROWS    (jtc_pkg::ROWS),
    .ROW_W   (jtc_pkg::ROW_W)
  ) u_otp (
    .clock       (clock),
    .rst         (rst),
    .req         (otp_req),
    .sector_lock (sec[jtc_pkg::SEC_LOCK0 +: jtc_pkg::SECTORS]),
    .master_lock (sec[jtc_pkg::SEC_MASTER]),
    .rd_data     (otp_q),
    .wr_refused  (wr_refused)
  );

  // boot sequencer
  always_comb begin
    bt_req      = '0;
    bt_req.addr = 11'(row + 11'h001);
    case (boot_st)
      jtc_pkg::BT_HOLD: next_boot_st = jtc_pkg::BT_LOCK;
      jtc_pkg::BT_LOCK: begin
        bt_req.rd    = pll_lock;
        bt_req.addr  = jtc_pkg::SEC_ROW;
        next_boot_st = pll_lock ? jtc_pkg::BT_SEC : jtc_pkg::BT_LOCK;
      end
      jtc_pkg::BT_SEC: begin
        bt_req.rd    = 1'b1;
        bt_req.addr  = '0;
        next_boot_st = jtc_pkg::BT_COPY;
      end
      jtc_pkg::BT_COPY: begin
        bt_req.rd    = row != 11'(jtc_pkg::SEC_ROW - 11'h001);
        next_boot_st = bt_req.rd ? jtc_pkg::BT_COPY : jtc_pkg::BT_RUN;
      end
      jtc_pkg::BT_RUN: next_boot_st = jtc_pkg::BT_RUN;
      default:         next_boot_st = jtc_pkg::BT_HOLD;
    endcase
  end

  always_ff @(posedge clock or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      boot_st <= jtc_pkg::BT_HOLD;
    end else if (rst) begin
      boot_st <= jtc_pkg::BT_HOLD;
    end else begin
      boot_st <= next_boot_st;
    end
  end

  always_ff @(posedge clock or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      sec       <= jtc_pkg::SEC_RESET;
      sec_valid <= 1'b0;
      boot_otp  <= 1'b0;
    end else if (rst) begin
      sec       <= jtc_pkg::SEC_RESET;
      sec_valid <= 1'b0;
      boot_otp  <= 1'b0;
    end else if (boot_st == jtc_pkg::BT_SEC) begin
      sec       <= otp_q;
      sec_valid <= 1'b1;
      boot_otp  <= otp_q[jtc_pkg::SEC_SECURE];
    end
  end

  always_ff @(posedge clock or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      row        <= '0;
      sram_we    <= 1'b0;
      sram_addr  <= '0;
      sram_data  <= '0;
      core_start <= 1'b0;
    end else if (rst) begin
      row        <= '0;
      sram_we    <= 1'b0;
      sram_addr  <= '0;
      sram_data  <= '0;
      core_start <= 1'b0;
    end else begin
      sram_we    <= boot_st == jtc_pkg::BT_COPY;
      core_start <= boot_st == jtc_pkg::BT_RUN;
      if (boot_st == jtc_pkg::BT_COPY) begin
        sram_addr <= row;
        sram_data <= otp_q;
        row       <= 11'(row + 11'h001);
      end
    end
  end
endmodule : jtc_top

// >>> rtl/jtc_pkg.sv
package jtc_pkg;
  localparam int IR_W  = 4;
  localparam int SR_W  = 64;
  localparam int LEN_W = 7;

  // instruction codes, shared by both controllers
  localparam logic [3:0] INS_EXTEST  = 4'h0;
  localparam logic [3:0] INS_SAMPLE  = 4'h1;
  localparam logic [3:0] INS_IDENT   = 4'h2;
  localparam logic [3:0] INS_UCODE   = 4'h3;
  localparam logic [3:0] INS_OTP_ADR = 4'h4;
  localparam logic [3:0] INS_OTP_DAT = 4'h5;
  localparam logic [3:0] INS_OTP_CTL = 4'h6;
  localparam logic [3:0] INS_DEBUG   = 4'h8;
  localparam logic [3:0] INS_BYPASS  = 4'hF;
  localparam logic [3:0] IR_CAPTURE  = 4'h1;

  // data register lengths
  localparam logic [6:0] LEN_ID  = 7'h20;
  localparam logic [6:0] LEN_ADR = 7'h10;
  localparam logic [6:0] LEN_DAT = 7'h20;
  localparam logic [6:0] LEN_CTL = 7'h10;
  localparam logic [6:0] LEN_DBG = 7'h28;
  localparam logic [6:0] LEN_BYP = 7'h01;

  // internal programming port identifiers
  localparam logic [23:0] PORT_ID_ADR = 24'h100200;
  localparam logic [23:0] PORT_ID_DAT = 24'h200100;
  localparam logic [23:0] PORT_ID_CTL = 24'h100300;

  // otp organisation
  localparam int SECTORS = 4;
  localparam int ROWS    = 512;
  localparam int ROW_W   = 32;
  localparam int OTP_AW  = 11;
  localparam int ROW_AW  = 9;
  localparam logic [10:0] SEC_ROW = 11'h7FF;

  // security word fields
  localparam logic [31:0] SEC_RESET   = 32'h0000_0000;
  localparam int SEC_PORT_OFF = 0;
  localparam int SEC_SECURE   = 5;
  localparam int SEC_LOCK0    = 8;
  localparam int SEC_MASTER   = 12;
  localparam int SEC_OTP_OFF  = 13;
  localparam int SEC_UID_LSB  = 22;
  localparam int UID_W        = 10;

  // otp control and status fields
  localparam int CTL_RD      = 0;
  localparam int CTL_PROG    = 1;
  localparam int ST_DENIED   = 0;
  localparam int ST_REFUSED  = 1;

  typedef enum logic [15:0] {
    TS_RESET  = 16'h0001, TS_IDLE   = 16'h0002, TS_SEL_DR = 16'h0004, TS_CAP_DR = 16'h0008,
    TS_SH_DR  = 16'h0010, TS_EX1_DR = 16'h0020, TS_PA_DR  = 16'h0040, TS_EX2_DR = 16'h0080,
    TS_UPD_DR = 16'h0100, TS_SEL_IR = 16'h0200, TS_CAP_IR = 16'h0400, TS_SH_IR  = 16'h0800,
    TS_EX1_IR = 16'h1000, TS_PA_IR  = 16'h2000, TS_EX2_IR = 16'h4000, TS_UPD_IR = 16'h8000
  } jtc_tap_e;

  typedef enum logic [4:0] {
    BT_HOLD = 5'h01, BT_LOCK = 5'h02, BT_SEC = 5'h04, BT_COPY = 5'h08, BT_RUN = 5'h10
  } jtc_boot_e;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [10:0] addr;
    logic [31:0] data;
  } jtc_otp_req_s;
endpackage : jtc_pkg

// >>> rtl/jtc_tap.sv
`timescale 1ns/1ps
module jtc_tap #(
  parameter logic [3:0] IR_RESET = jtc_pkg::INS_IDENT
) (
  // clock and resets
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             trst_n,
  input  wire logic             hold,
  // test port
  input  wire logic             tck_rise,
  input  wire logic             tms,
  input  wire logic             tdi,
  // controller view
  output jtc_pkg::jtc_tap_e     state,
  output logic [3:0]            ir,
  output logic                  ir_tdo
);
  jtc_pkg::jtc_tap_e next_state;
  logic [3:0]        ir_sr;

  always_comb begin
    case (state)
      jtc_pkg::TS_RESET:  next_state = tms ? jtc_pkg::TS_RESET  : jtc_pkg::TS_IDLE;
      jtc_pkg::TS_IDLE:   next_state = tms ? jtc_pkg::TS_SEL_DR : jtc_pkg::TS_IDLE;
      jtc_pkg::TS_SEL_DR: next_state = tms ? jtc_pkg::TS_SEL_IR : jtc_pkg::TS_CAP_DR;
      jtc_pkg::TS_CAP_DR: next_state = tms ? jtc_pkg::TS_EX1_DR : jtc_pkg::TS_SH_DR;
      jtc_pkg::TS_SH_DR:  next_state = tms ? jtc_pkg::TS_EX1_DR : jtc_pkg::TS_SH_DR;
      jtc_pkg::TS_EX1_DR: next_state = tms ? jtc_pkg::TS_UPD_DR : jtc_pkg::TS_PA_DR;
      jtc_pkg::TS_PA_DR:  next_state = tms ? jtc_pkg::TS_EX2_DR : jtc_pkg::TS_PA_DR;
      jtc_pkg::TS_EX2_DR: next_state = tms ? jtc_pkg::TS_UPD_DR : jtc_pkg::TS_SH_DR;
      jtc_pkg::TS_UPD_DR: next_state = tms ? jtc_pkg::TS_SEL_DR : jtc_pkg::TS_IDLE;
      jtc_pkg::TS_SEL_IR: next_state = tms ? jtc_pkg::TS_RESET  : jtc_pkg::TS_CAP_IR;
      jtc_pkg::TS_CAP_IR: next_state = tms ? jtc_pkg::TS_EX1_IR : jtc_pkg::TS_SH_IR;
      jtc_pkg::TS_SH_IR:  next_state = tms ? jtc_pkg::TS_EX1_IR : jtc_pkg::TS_SH_IR;
      jtc_pkg::TS_EX1_IR: next_state = tms ? jtc_pkg::TS_UPD_IR : jtc_pkg::TS_PA_IR;
      jtc_pkg::TS_PA_IR:  next_state = tms ? jtc_pkg::TS_EX2_IR : jtc_pkg::TS_PA_IR;
      jtc_pkg::TS_EX2_IR: next_state = tms ? jtc_pkg::TS_UPD_IR : jtc_pkg::TS_SH_IR;
      jtc_pkg::TS_UPD_IR: next_state = tms ? jtc_pkg::TS_SEL_DR : jtc_pkg::TS_IDLE;
      default:            next_state = jtc_pkg::TS_RESET;
    endcase
  end

  // test reset clears without the clock
  always_ff @(posedge clock or negedge trst_n) begin
    if (!trst_n) begin
      state <= jtc_pkg::TS_RESET;
    end else if (rst || hold) begin
      state <= jtc_pkg::TS_RESET;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock or negedge trst_n) begin
    if (!trst_n) begin
      ir_sr <= jtc_pkg::IR_CAPTURE;
      ir    <= IR_RESET;
    end else if (rst || hold || state == jtc_pkg::TS_RESET) begin
      ir_sr <= jtc_pkg::IR_CAPTURE;
      ir    <= IR_RESET;
    end else if (tck_rise) begin
      case (state)
        jtc_pkg::TS_CAP_IR: ir_sr <= jtc_pkg::IR_CAPTURE;
        jtc_pkg::TS_SH_IR:  ir_sr <= {tdi, ir_sr[3:1]};
        jtc_pkg::TS_UPD_IR: ir    <= ir_sr;
        default:            ir_sr <= ir_sr;
      endcase
    end
  end

  assign ir_tdo = ir_sr[0];
endmodule : jtc_tap

// >>> rtl/jtc_otp.sv
`timescale 1ns/1ps
module jtc_otp #(
  parameter int SECTORS = 4,
  parameter int ROWS    = 512,
  parameter int ROW_W   = 32
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst,
  // access
  input  jtc_pkg::jtc_otp_req_s     req,
  input  wire logic [SECTORS-1:0]   sector_lock,
  input  wire logic                 master_lock,
  output logic [ROW_W-1:0]          rd_data,
  output logic                      wr_refused
);
  // blank part reads as all zeros
  logic [ROW_W-1:0] mem [SECTORS*ROWS] = '{default: '0};
  logic [1:0]       sector;
  logic             locked;

  assign sector = req.addr[jtc_pkg::OTP_AW-1:jtc_pkg::ROW_AW];
  assign locked = master_lock || sector_lock[sector];

  // fuses only ever go from zero to one
  always_ff @(posedge clock) begin
    if (req.wr && !locked) begin
      mem[req.addr] <= mem[req.addr] | req.data[ROW_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data    <= '0;
      wr_refused <= 1'b0;
    end else begin
      if (req.rd) begin
        rd_data <= mem[req.addr];
      end
      wr_refused <= req.wr && locked;
    end
  end
endmodule : jtc_otp

// >>> testbench/jtc_monitor.sv
`timescale 1ns/1ps
module jtc_monitor (
  // clock and resets
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        sys_rst_n,
  input wire logic        trst_n,
  // test port
  input wire logic        tck,
  input wire logic        tdo,
  input wire logic        tdo_oe_n,
  // boot and debug
  input wire logic        dbg_wr,
  input wire logic        sram_we,
  input wire logic [10:0] sram_addr,
  input wire logic        core_start,
  input wire logic [23:0] otp_port_id
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_copy_mid;
    sram_we && sram_addr != 11'h7FE;
  endsequence
  property p_trst_quiet; !trst_n |-> tdo_oe_n && !tdo; endproperty
  a_trst_quiet: assert property (p_trst_quiet) else $error("tdo active in test reset");
  // tdo is seen to move one edge after the clock saw tck fall
  property p_tdo_hold;
    $changed(tdo) && trst_n && $past(trst_n) |-> !$past(tck) && $past(tck, 2);
  endproperty
  a_tdo_hold: assert property (p_tdo_hold) else $error("tdo moved off the tck fall");
  property p_sys_hold; !sys_rst_n |-> !core_start && !sram_we; endproperty
  a_sys_hold: assert property (p_sys_hold) else $error("boot active in system reset");
  property p_copy_next; s_copy_mid |=> sram_we && sram_addr == $past(sram_addr) + 11'h1; endproperty
  a_copy_next: assert property (p_copy_next) else $error("copy rows not consecutive");
  property p_copy_end; sram_we && sram_addr == 11'h7FE |=> !sram_we; endproperty
  a_copy_end: assert property (p_copy_end) else $error("security row copied");
  property p_start_late; $rose(core_start) |-> $past(sram_addr) == 11'h7FE; endproperty
  a_start_late: assert property (p_start_late) else $error("core started before copy end");
  property p_dbg_pulse; dbg_wr |=> !dbg_wr; endproperty
  a_dbg_pulse: assert property (p_dbg_pulse) else $error("debug write longer than a cycle");
  property p_port_id;
    $changed(otp_port_id) |-> otp_port_id inside {24'h0, 24'h100200, 24'h200100, 24'h100300};
  endproperty
  a_port_id: assert property (p_port_id) else $error("unknown programming port");
endmodule : jtc_monitor

bind jtc_top jtc_monitor u_mon (.clock(clock), .rst(rst), .sys_rst_n(sys_rst_n),
  .trst_n(trst_n), .tck(tck), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .dbg_wr(dbg_wr),
  .sram_we(sram_we), .sram_addr(sram_addr), .core_start(core_start), .otp_port_id(otp_port_id));

// >>> testbench/jtc_probe.sv
`timescale 1ns/1ps
module jtc_probe (
  // timing
  input wire logic clock,
  input wire logic tdo,
  // test port
  output logic     tck,
  output logic     tms,
  output logic     tdi,
  output logic     trst_n
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b0;
    repeat (20) @(posedge clock);
    #1 trst_n = 1'b1;
  end
  // three clocks per phase, above the two-cycle minimum
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    repeat (3) @(posedge clock);
    #1 q = tdo;
    tck = 1'b1;
    repeat (3) @(posedge clock);
    #1 tck = 1'b0;
  endtask : step
  task automatic nav(input logic [7:0] seq, input int n);
    logic q;
    for (int i = 0; i < n; i++) step(seq[i], 1'b0, q);
  endtask : nav
  task automatic scan(input logic [63:0] v, input int n, output logic [63:0] r);
    r = '0;
    for (int i = 0; i < n; i++) step(i == n - 1, v[i], r[i]);
    nav(8'h01, 2);
  endtask : scan
  task automatic pulse_trst();
    trst_n = 1'b0;
    repeat (3) @(posedge clock);
    #1 trst_n = 1'b1;
  endtask : pulse_trst
endmodule : jtc_probe

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        clock, rst, sys_rst_n, pll_lock, tck, tms, tdi, trst_n, tdo, sram_we, core_start;
  int          n_fail, samples_checked, n_rows;
  logic [7:0]  core_out, core_oe_n, pad_in, pad_out, pad_oe_n;
  logic [31:0] dbg_rd_data;
  logic [23:0] otp_port_id;
  logic [63:0] got;
  localparam logic [31:0] ID_WORD = {4'h3, 16'h5A01, 11'h2A6, 1'b1};
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  jtc_probe u_probe (.clock(clock), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n));
  jtc_top #(.ID_VERSION(4'h3), .ID_PART(16'h5A01), .ID_MAKER(11'h2A6), .SI_REV(16'h0042)) dut (
    .clock(clock), .rst(rst), .sys_rst_n(sys_rst_n), .pll_lock(pll_lock), .tck(tck),
    .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe_n(), .core_out(core_out),
    .core_oe_n(core_oe_n), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .dbg_wr(), .dbg_word(), .dbg_rd_data(dbg_rd_data), .sram_we(sram_we), .sram_addr(),
    .sram_data(), .core_start(core_start), .boot_otp(), .otp_port_id(otp_port_id));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] act);
    samples_checked++;
    if (act !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, act);
    end
  endtask : check
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  task automatic read_ident(input string what);
    u_probe.nav(8'h1F, 6);
    u_probe.nav(8'h01, 3);
    u_probe.scan(64'h0, 64, got);
    check(what, ID_WORD, got[31:0]);
    check("boundary id", ID_WORD, got[63:32]);
  endtask : read_ident
  initial begin
    n_fail = 0;
    samples_checked = 0;
    n_rows = 0;
    core_out = 8'hA5;
    core_oe_n = 8'h0F;
    pad_in = 8'h3C;
    dbg_rd_data = 32'h1234_5678;
    rst = 1'b1;
    sys_rst_n = 1'b0;
    pll_lock = 1'b0;
    repeat (16) @(posedge clock);
    #1 rst = 1'b0;
    repeat (4) @(posedge clock);
    #1 sys_rst_n = 1'b1;
    repeat (8) @(posedge clock);
    #1 check("boot before lock", 32'h0, {31'h0, core_start | sram_we});
    // pads pass the core values while not under external test
    check("pad out", 32'hA5, {24'h0, pad_out});
    check("pad enable", 32'h0F, {24'h0, pad_oe_n});
    pll_lock = 1'b1;
    // bounded wait; rows counted one per cycle
    for (int i = 0; i < 2200 && !core_start; i++) begin
      @(posedge clock);
      #1 n_rows += sram_we;
    end
    check("rows copied", 32'd2047, n_rows);
    check("core start", 32'h1, {31'h0, core_start});
    read_ident("chip id");
    u_probe.nav(8'h03, 4);
    u_probe.scan({56'h0, 4'hF, 4'h3}, 8, got);
    check("ir capture", 32'h11, {24'h0, got[7:0]});
    u_probe.nav(8'h01, 3);
    u_probe.scan(64'h0, 33, got);
    check("user code", {10'h0, 6'h0, 16'h0042}, got[31:0]);
    check("bypass bit", 32'h0, {31'h0, got[32]});
    // chip otp control, boundary bypass; request a read of row zero
    u_probe.nav(8'h03, 4);
    u_probe.scan({56'h0, 8'hF6}, 8, got);
    u_probe.nav(8'h01, 3);
    u_probe.scan(64'h1, 17, got);
    check("ctl port", 32'h100300, {8'h0, otp_port_id});
    u_probe.nav(8'h01, 3);
    u_probe.scan(64'h0, 17, got);
    check("otp status", 32'h0, got[31:0]);
    // chip debug register captures the tile's read word
    u_probe.nav(8'h03, 4);
    u_probe.scan({56'h0, 8'hF8}, 8, got);
    u_probe.nav(8'h01, 3);
    u_probe.scan(64'h0, 41, got);
    check("debug capture", 32'h1234_5678, got[31:0]);
    u_probe.pulse_trst();
    read_ident("id after test reset");
    end_of_test();
  end
  initial begin
    #600000;
    n_fail++;
    end_of_test();
  end
endmodule : tb_top
